// ===== hw/boot_serial_frame_protocol.sv
// Target-side framing engine for a serial boot-loading link.
// Assumes a byte receiver/transmitter pair on pins and a command handler
// on the user side that answers each command with a status.
`timescale 1ns/100ps

// Summary of operation
// - Every host command gets a concluding reply
// - Inbound data: cmd, reply, data, final reply
// - Non-ok first reply cancels inbound data
// - Inbound phase ends by abort status or empty
// - Final reply carries whole-operation status
// - Outbound data: cmd, read reply, data, reply
// - Read reply lacking data flag cancels phase
// - Outbound phase ends by host abort or empty
// - Target only answers, never starts traffic
// - Multi-byte fields go low byte first
// - Measure bit rate before probe reply
// - Probe reply is ten fixed-order bytes
// - Each payload frame answered by sync frame
// - Header: start, type, length, CRC, payload
// - CRC covers all bytes except CRC field
// - Sync frame is start byte plus type
// - Sync codes accept, retry, cancel
// - Type byte routes command versus data payload
// - CRC16 poly 1021, zero init, no reflect
// - Flag bit 0 announces a data phase
// - General reply: tag A0, two parameters
module boot_serial_frame_protocol
	import frame_pkg::*;
(
	input  wire logic        clock_i,       // 10 MHz system clock
	input  wire logic        sys_rst_i,     // Synchronous reset, active high
	input  wire logic        ce_i,          // Clock enable, freezes state when low
	input  wire logic        rx_pin_i,      // Serial receive line, for rate measurement
	input  wire logic        rx_valid_i,    // Received byte strobe (from pin domain)
	input  wire logic [7:0]  rx_byte_i,     // Received byte
	input  wire logic        tx_ready_i,    // Transmitter can take a byte
	input  wire logic        rsp_valid_i,   // Handler status ready for current command
	input  wire logic [31:0] rsp_status_i,  // Handler status word
	input  wire logic        rsp_read_i,    // Handler answers with a read reply
	input  wire logic        rsp_data_i,    // Read reply announces outbound data
	input  wire logic        out_valid_i,   // Outbound data byte offered
	input  wire logic [7:0]  out_byte_i,    // Outbound data byte
	input  wire logic        out_last_i,    // Outbound byte closes its packet
	input  wire logic        out_done_i,    // Outbound phase finished
	output logic             tx_valid_o,    // Byte to transmitter valid
	output logic      [7:0]  tx_byte_o,     // Byte to transmitter
	output logic             out_ready_o,   // Outbound byte taken
	output logic             cmd_valid_o,   // Good command frame delivered
	output logic      [7:0]  cmd_tag_o,     // Delivered command tag
	output logic             cmd_data_o,    // Delivered command has data phase
	output logic             data_valid_o,  // Inbound payload byte strobe
	output logic      [7:0]  data_byte_o,   // Inbound payload byte
	output logic             data_end_o,    // Inbound phase ended (empty payload packet)
	output logic             out_abort_o,   // Host cancelled outbound phase
	output logic      [8:0]  bit_period_o,  // Measured bit period in clocks
	output logic             linked_o       // Probe exchanged, link open
);
	typedef enum logic [2:0] {
		RX_START = 3'b000,
		RX_TYPE  = 3'b001,
		RX_HDR   = 3'b010,
		RX_BODY  = 3'b011
	} rx_state_type;

	typedef enum logic [2:0] {
		TX_IDLE  = 3'b000,
		TX_SYNC  = 3'b001,
		TX_PROBE = 3'b010,
		TX_REPLY = 3'b011,
		TX_DATA  = 3'b100
	} tx_state_type;

	logic [1:0]   rxv_sync_r;
	logic [1:0]   pin_sync_r;
	logic         rxv_seen_r;
	rx_state_type rx_r;
	tx_state_type tx_r;
	logic [7:0]   type_r;
	logic [2:0]   hidx_r;
	logic [15:0]  len_r;
	logic [15:0]  crc_rx_r;
	logic [15:0]  cnt_r;
	logic [7:0]   cmd_flags_r;
	logic         in_phase_r;
	logic         out_phase_r;
	logic         final_pend_r;
	logic [1:0]   sync_code_r;
	logic         sync_pend_r;
	logic         probe_pend_r;
	logic [4:0]   tidx_r;
	logic         in_open_r;
	logic [8:0]   baud_cnt_r;
	logic         baud_run_r;
	logic         pin_q_r;
	logic [15:0]  crc_val;
	logic         rx_stb;
	logic         crc_clear;
	logic         crc_feed;
	logic [7:0]   crc_byte;
	logic [7:0]   tx_nxt;
	logic [15:0]  tx_crc_r;

	// Byte strobe and serial line come from the pin domain: two stages each
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			rxv_sync_r <= 2'h0;
			pin_sync_r <= 2'h3;
			rxv_seen_r <= 1'b0;
			pin_q_r    <= 1'b1;
		end else if (ce_i) begin
			rxv_sync_r <= {rxv_sync_r[0], rx_valid_i};
			pin_sync_r <= {pin_sync_r[0], rx_pin_i};
			rxv_seen_r <= rxv_sync_r[1];
			pin_q_r    <= pin_sync_r[1];
		end
	end

	assign rx_stb = ce_i && rxv_sync_r[1] && !rxv_seen_r;

	// Bit-rate measurement: the start byte's first low run is two bits long
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			baud_cnt_r   <= 9'h000;
			baud_run_r   <= 1'b0;
			bit_period_o <= 9'h000;
		end else if (ce_i && !linked_o) begin
			if (pin_q_r && !pin_sync_r[1] && bit_period_o == 9'h000) begin
				baud_run_r <= 1'b1;
				baud_cnt_r <= 9'h001;
			end else if (baud_run_r && !pin_sync_r[1]) begin
				if (baud_cnt_r != BAUD_CNT_MAX) begin
					baud_cnt_r <= baud_cnt_r + 9'h001;
				end
			end else if (baud_run_r) begin
				baud_run_r   <= 1'b0;
				bit_period_o <= baud_cnt_r >> 1;
			end
		end
	end

	// CRC over start, type, length and payload; CRC bytes skipped
	assign crc_clear = rx_stb && rx_r == RX_START;
	assign crc_feed  = rx_stb && rx_r != RX_START && !(rx_r == RX_HDR && hidx_r >= 3'h2);
	assign crc_byte  = rx_byte_i;

	crc16_acc rx_crc (
		.clock_i   (clock_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.clear_i   (crc_clear),
		.feed_i    (crc_feed || crc_clear),
		.byte_i    (crc_clear ? START_BYTE : crc_byte),
		.crc_o     (crc_val)
	);

	// Receive parser; link stays closed to frames until the probe reply has gone out
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			rx_r          <= RX_START;
			type_r        <= 8'h00;
			hidx_r        <= 3'h0;
			len_r         <= 16'h0000;
			crc_rx_r      <= 16'h0000;
			cnt_r         <= 16'h0000;
			linked_o      <= 1'b0;
			probe_pend_r  <= 1'b0;
			sync_pend_r   <= 1'b0;
			sync_code_r   <= 2'h0;
			cmd_valid_o   <= 1'b0;
			cmd_tag_o     <= 8'h00;
			cmd_data_o    <= 1'b0;
			cmd_flags_r   <= 8'h00;
			data_valid_o  <= 1'b0;
			data_byte_o   <= 8'h00;
			data_end_o    <= 1'b0;
			out_abort_o   <= 1'b0;
			in_phase_r    <= 1'b0;
		end else if (ce_i) begin
			cmd_valid_o  <= 1'b0;
			data_valid_o <= 1'b0;
			data_end_o   <= 1'b0;
			out_abort_o  <= 1'b0;
			if (tx_r == TX_PROBE && tidx_r == PROBE_REPLY_LEN - 4'h1 && tx_ready_i) begin
				probe_pend_r <= 1'b0;
				linked_o     <= 1'b1;
			end
			if (tx_r == TX_SYNC && tx_ready_i && tx_valid_o && tidx_r == 5'h01) begin
				sync_pend_r <= 1'b0;
			end
			if (tx_r == TX_REPLY && final_pend_r && tidx_r == GEN_REPLY_LEN - 5'h01
				&& tx_ready_i) begin
				in_phase_r <= 1'b0;
			end
			if (in_open_r) begin
				in_phase_r <= 1'b1;
			end
			if (rx_stb) begin
				case (rx_r)
					RX_START: begin
						if (rx_byte_i == START_BYTE) begin
							rx_r <= RX_TYPE;
						end
					end
					RX_TYPE: begin
						type_r <= rx_byte_i;
						hidx_r <= 3'h0;
						rx_r   <= RX_START;
						if (rx_byte_i == FRAME_TYPE_PROBE && !probe_pend_r) begin
							probe_pend_r <= 1'b1;
						end else if (linked_o && (rx_byte_i == FRAME_TYPE_CMD
							|| rx_byte_i == FRAME_TYPE_PAYLOAD)) begin
							rx_r <= RX_HDR;
						end else if (linked_o && rx_byte_i == FRAME_TYPE_CANCEL
							&& out_phase_r) begin
							out_abort_o <= 1'b1;
						end
					end
					RX_HDR: begin
						hidx_r <= hidx_r + 3'h1;
						case (hidx_r)
							3'h0: len_r[7:0]     <= rx_byte_i;
							3'h1: len_r[15:8]    <= rx_byte_i;
							3'h2: crc_rx_r[7:0]  <= rx_byte_i;
							default: crc_rx_r[15:8] <= rx_byte_i;
						endcase
						if (hidx_r == 3'h3) begin
							cnt_r <= 16'h0000;
							rx_r  <= (len_r == 16'h0000) ? RX_START : RX_BODY;
							if (len_r == 16'h0000) begin
								sync_pend_r <= 1'b1;
								sync_code_r <= 2'h1;
								if (type_r == FRAME_TYPE_PAYLOAD && in_phase_r) begin
									data_end_o <= 1'b1;
								end
							end
						end
					end
					RX_BODY: begin
						cnt_r <= cnt_r + 16'h0001;
						if (type_r == FRAME_TYPE_CMD) begin
							if (cnt_r == 16'h0000) cmd_tag_o   <= rx_byte_i;
							if (cnt_r == 16'h0001) cmd_flags_r <= rx_byte_i;
						end else if (in_phase_r) begin
							data_valid_o <= 1'b1;
							data_byte_o  <= rx_byte_i;
						end
						if (cnt_r == len_r - 16'h0001) begin
							rx_r        <= RX_START;
							sync_pend_r <= 1'b1;
							if (crc_step16(crc_val, rx_byte_i) != crc_rx_r) begin
								sync_code_r <= 2'h2;
							end else begin
								sync_code_r <= 2'h1;
								if (type_r == FRAME_TYPE_CMD) begin
									cmd_valid_o <= 1'b1;
									cmd_data_o  <= cmd_flags_r[HAS_DATA_PHASE_BIT];
								end
							end
						end
					end
					default: rx_r <= RX_START;
				endcase
			end
		end
	end

	// Last payload byte is folded here since the accumulator lags one cycle
	function automatic logic [15:0] crc_step16(input logic [15:0] c, input logic [7:0] d);
		return crc16_step(c, d);
	endfunction

	// Reply bookkeeping: replies exist only as answers to host commands
	logic        reply_pend_r;
	logic [7:0]  reply_tag_r;
	logic [31:0] reply_stat_r;
	logic        reply_read_r;
	logic        reply_data_r;
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			reply_pend_r <= 1'b0;
			reply_tag_r  <= 8'h00;
			reply_stat_r <= STATUS_OK_CODE;
			reply_read_r <= 1'b0;
			reply_data_r <= 1'b0;
			final_pend_r <= 1'b0;
			out_phase_r  <= 1'b0;
		end else if (ce_i) begin
			if (cmd_valid_o) begin
				reply_tag_r <= cmd_tag_o;
			end
			if (rsp_valid_i && !reply_pend_r) begin
				reply_pend_r <= 1'b1;
				reply_stat_r <= rsp_status_i;
				reply_read_r <= rsp_read_i;
				reply_data_r <= rsp_data_i;
				final_pend_r <= in_phase_r || out_phase_r;
			end
			if (tx_r == TX_REPLY && tidx_r == GEN_REPLY_LEN - 5'h01 && tx_ready_i
				&& tx_valid_o) begin
				reply_pend_r <= 1'b0;
				out_phase_r  <= reply_read_r && reply_data_r;
				if (final_pend_r) begin
					out_phase_r <= 1'b0;
				end
			end
			if (out_done_i || out_abort_o) begin
				out_phase_r <= 1'b0;
			end
		end
	end

	// Inbound phase opens on an ok first reply to a flagged command
	logic in_open;
	assign in_open = tx_r == TX_REPLY && !final_pend_r && cmd_data_o && !reply_read_r
		&& reply_stat_r == STATUS_OK_CODE;

	// Transmit sequencer: sync frames first, then probe reply, then replies, then data
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			tx_r        <= TX_IDLE;
			tidx_r      <= 5'h00;
			tx_valid_o  <= 1'b0;
			tx_byte_o   <= 8'h00;
			out_ready_o <= 1'b0;
			tx_crc_r    <= CRC_INIT;
		end else if (ce_i) begin
			out_ready_o <= 1'b0;
			case (tx_r)
				TX_IDLE: begin
					tidx_r     <= 5'h00;
					tx_valid_o <= 1'b0;
					tx_crc_r   <= CRC_INIT;
					if (sync_pend_r) begin
						tx_r <= TX_SYNC;
					end else if (probe_pend_r && bit_period_o != 9'h000) begin
						tx_r <= TX_PROBE;
					end else if (reply_pend_r) begin
						tx_r <= TX_REPLY;
					end else if (out_phase_r && out_valid_i) begin
						tx_r <= TX_DATA;
					end
				end
				default: begin
					if (!tx_valid_o) begin
						tx_valid_o <= 1'b1;                       // Offer the byte at tidx_r
						tx_byte_o  <= tx_nxt;
					end else if (tx_ready_i) begin
						tidx_r     <= tidx_r + 5'h01;
						tx_valid_o <= 1'b0;                       // Gap lets tx_nxt follow tidx_r
						if (tidx_r < 5'h08) begin                 // CRC bytes not folded
							tx_crc_r <= crc16_step(tx_crc_r, tx_byte_o);
						end
						if ((tx_r == TX_SYNC && tidx_r == 5'h01)
							|| (tx_r == TX_PROBE && tidx_r == {1'b0, PROBE_REPLY_LEN} - 5'h01)
							|| (tx_r == TX_REPLY && tidx_r == GEN_REPLY_LEN - 5'h01)
							|| (tx_r == TX_DATA && out_last_i)) begin
							tx_r       <= TX_IDLE;
							tx_valid_o <= 1'b0;
						end
						if (tx_r == TX_DATA) begin
							out_ready_o <= 1'b1;
						end
					end
				end
			endcase
		end
	end

	// Inbound phase flag lives with receive state; opened from reply send
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			in_open_r <= 1'b0;
		end else if (ce_i) begin
			in_open_r <= in_open && tidx_r == GEN_REPLY_LEN - 5'h01 && tx_ready_i;
		end
	end

	// Reply CRC precedes the payload it covers, so it is worked out whole
	function automatic logic [15:0] reply_crc(input logic [95:0] pl);
		logic [15:0] c;
		c = crc16_step(crc16_step(CRC_INIT, START_BYTE), FRAME_TYPE_CMD);
		c = crc16_step(crc16_step(c, GEN_REPLY_PAYLOAD_LEN), 8'h00);
		for (int i = 0; i < 12; i++) begin
			c = crc16_step(c, pl[8*i +: 8]);
		end
		return c;
	endfunction

	// Reply header fields and frame CRC
	logic [7:0]  rep_tag;
	logic [7:0]  rep_flag;
	logic [15:0] rep_crc;
	assign rep_tag  = (reply_read_r && !final_pend_r) ? MEMORY_READ_REPLY_TAG
		: GENERAL_REPLY_TAG;
	assign rep_flag = {7'h00, reply_read_r && reply_data_r && !final_pend_r};
	assign rep_crc  = reply_crc({24'h000000, reply_tag_r, reply_stat_r, REPLY_PARAM_COUNT,
		8'h00, rep_flag, rep_tag});

	// Byte chooser for each outgoing frame, all fields low byte first
	always_comb begin
		tx_nxt = START_BYTE;
		case (tx_r)
			TX_SYNC: tx_nxt = (tidx_r == 5'h00) ? START_BYTE :
				(sync_code_r == 2'h2 ? FRAME_TYPE_RETRY : FRAME_TYPE_ACCEPT);
			TX_PROBE: begin
				case (tidx_r)
					5'h00: tx_nxt = START_BYTE;
					5'h01: tx_nxt = FRAME_TYPE_PROBE_REPLY;
					5'h02: tx_nxt = PROTO_BUGFIX;
					5'h03: tx_nxt = PROTO_MINOR;
					5'h04: tx_nxt = PROTO_MAJOR;
					5'h05: tx_nxt = PROTO_NAME_BYTE;
					5'h06: tx_nxt = PROTO_OPTIONS[7:0];
					5'h07: tx_nxt = PROTO_OPTIONS[15:8];
					5'h08: tx_nxt = tx_crc_r[7:0];
					default: tx_nxt = tx_crc_r[15:8];
				endcase
			end
			TX_REPLY: begin
				case (tidx_r)
					5'h00: tx_nxt = START_BYTE;
					5'h01: tx_nxt = FRAME_TYPE_CMD;
					5'h02: tx_nxt = GEN_REPLY_PAYLOAD_LEN;
					5'h03: tx_nxt = 8'h00;
					5'h04: tx_nxt = rep_crc[7:0];
					5'h05: tx_nxt = rep_crc[15:8];
					5'h06: tx_nxt = rep_tag;
					5'h07: tx_nxt = rep_flag;
					5'h08: tx_nxt = 8'h00;
					5'h09: tx_nxt = REPLY_PARAM_COUNT;
					5'h0A: tx_nxt = reply_stat_r[7:0];
					5'h0B: tx_nxt = reply_stat_r[15:8];
					5'h0C: tx_nxt = reply_stat_r[23:16];
					5'h0D: tx_nxt = reply_stat_r[31:24];
					5'h0E: tx_nxt = reply_tag_r;
					default: tx_nxt = 8'h00;
				endcase
			end
			TX_DATA: tx_nxt = out_byte_i;
			default: tx_nxt = START_BYTE;
		endcase
	end
endmodule

// ===== hw/frame_pkg.sv
// Shared constants of the serial boot framing engine.
// Assumes a byte-wide link below and a command handler above.
package frame_pkg;
	localparam logic [7:0]  START_BYTE             = 8'h5A;
	localparam logic [7:0]  FRAME_TYPE_ACCEPT      = 8'hA1;
	localparam logic [7:0]  FRAME_TYPE_RETRY       = 8'hA2;
	localparam logic [7:0]  FRAME_TYPE_CANCEL      = 8'hA3;
	localparam logic [7:0]  FRAME_TYPE_CMD         = 8'hA4;
	localparam logic [7:0]  FRAME_TYPE_PAYLOAD     = 8'hA5;
	localparam logic [7:0]  FRAME_TYPE_PROBE       = 8'hA6;
	localparam logic [7:0]  FRAME_TYPE_PROBE_REPLY = 8'hA7;
	localparam logic [7:0]  PROTO_NAME_BYTE        = 8'h50;
	localparam logic [15:0] CRC_POLY               = 16'h1021;
	localparam logic [15:0] CRC_INIT               = 16'h0000;
	localparam logic [7:0]  GENERAL_REPLY_TAG      = 8'hA0;
	localparam logic [7:0]  MEMORY_READ_REPLY_TAG  = 8'hA3;
	localparam logic [7:0]  REPLY_PARAM_COUNT      = 8'h02;
	localparam int          HAS_DATA_PHASE_BIT     = 0;
	localparam logic [31:0] STATUS_OK_CODE         = 32'h0000_0000;
	localparam logic [31:0] ABORT_DATA_PHASE_CODE  = 32'h0000_2712;
	localparam logic [7:0]  PROTO_BUGFIX           = 8'h00;
	localparam logic [7:0]  PROTO_MINOR            = 8'h02;
	localparam logic [7:0]  PROTO_MAJOR            = 8'h01;
	localparam logic [15:0] PROTO_OPTIONS          = 16'h0000;
	localparam logic [3:0]  PROBE_REPLY_LEN        = 4'hA;
	localparam logic [4:0]  GEN_REPLY_LEN          = 5'h12;
	localparam logic [7:0]  GEN_REPLY_PAYLOAD_LEN  = 8'h0C;
	localparam logic [8:0]  MAX_PAYLOAD            = 9'h100;
	localparam logic [8:0]  BAUD_CNT_MAX           = 9'h1FF;

	// One byte step of the CRC16 shift register, MSB first
	function automatic logic [15:0] crc16_step(input logic [15:0] crc, input logic [7:0] data);
		logic [15:0] c;
		c = crc ^ {data, 8'h00};
		for (int i = 0; i < 8; i++) begin
			c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
		end
		return c;
	endfunction
endpackage

// ===== hw/crc16_acc.sv
// CRC16 accumulator for framed packets.
// Assumes the caller clears it before each frame and feeds one byte per strobe.
`timescale 1ns/100ps
module crc16_acc
	import frame_pkg::*;
(
	input  wire logic        clock_i,   // System clock
	input  wire logic        sys_rst_i, // Synchronous reset
	input  wire logic        ce_i,      // Clock enable
	input  wire logic        clear_i,   // Restart at the initial value
	input  wire logic        feed_i,    // Byte strobe
	input  wire logic [7:0]  byte_i,    // Byte to fold in
	output logic      [15:0] crc_o      // Running CRC
);
	// Running remainder, zero initial value, no reflection or final xor
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			crc_o <= CRC_INIT;
		end else if (ce_i) begin
			if (clear_i) begin
				crc_o <= feed_i ? crc16_step(CRC_INIT, byte_i) : CRC_INIT; // Fold first byte
			end else if (feed_i) begin
				crc_o <= crc16_step(crc_o, byte_i);
			end
		end
	end
endmodule

// ===== dv/frame_props.sv
// Port checker for the boot framing engine.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module frame_props
	import frame_pkg::*;
(
	input wire logic       clock_i,      // System clock
	input wire logic       sys_rst_i,    // Synchronous reset
	input wire logic       tx_ready_i,   // Transmitter ready
	input wire logic       tx_valid_o,   // Byte offered
	input wire logic [7:0] tx_byte_o,    // Offered byte
	input wire logic       cmd_valid_o,  // Command delivered
	input wire logic       data_valid_o, // Inbound byte strobe
	input wire logic       data_end_o,   // Inbound phase ended
	input wire logic [8:0] bit_period_o, // Measured bit period
	input wire logic       linked_o      // Link open
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);

	// Transmitter stalls the offered byte
	sequence tx_wait_s;
		tx_valid_o && !tx_ready_i;
	endsequence
	// Strobe followed by a quiet cycle
	sequence cmd_once_s;
		cmd_valid_o ##1 !cmd_valid_o;
	endsequence

	tx_hold_a: assert property (tx_wait_s |=> tx_valid_o && $stable(tx_byte_o))
		else $error("offered byte changed before it was taken");
	rate_before_tx_a: assert property (tx_valid_o |-> bit_period_o != 9'h000)
		else $error("byte sent before the bit rate was measured");
	link_hold_a: assert property (linked_o |=> linked_o)
		else $error("link dropped without reset");
	cmd_link_a: assert property (cmd_valid_o |-> linked_o)
		else $error("command delivered before the probe");
	cmd_pulse_a: assert property (cmd_valid_o |-> cmd_once_s)
		else $error("command strobe longer than one cycle");
	data_route_a: assert property (data_valid_o |-> linked_o && !cmd_valid_o)
		else $error("payload byte routed with a command");
	data_pulse_a: assert property (data_valid_o |=> !data_valid_o)
		else $error("payload strobe longer than one cycle");
	end_pulse_a: assert property (data_end_o |=> !data_end_o && !data_valid_o)
		else $error("phase end strobe not single");
endmodule

// ===== dv/host_model.sv
// Host model: serialises bytes onto the line and strobes them in,
// and takes transmitted bytes, promptly or every other cycle.
`timescale 1ns/100ps
module host_model #(parameter int BIT = 8) (
	input  wire logic       clock_i,    // System clock
	input  wire logic       tx_valid_i, // Byte offered by target
	input  wire logic [7:0] tx_byte_i,  // Offered byte
	output logic            tx_ready_o, // Byte taken
	output logic            rx_pin_o,   // Serial line, idles high
	output logic            rx_valid_o, // Byte strobe
	output logic      [7:0] rx_byte_o   // Strobed byte
);
	logic [7:0] got[$];
	logic       slow;
	// Idle line and empty strobe at time zero
	initial begin
		slow = 1'b0;
		tx_ready_o = 1'b1;
		rx_pin_o = 1'b1;
		rx_valid_o = 1'b0;
		rx_byte_o = 8'h00;
	end
	// Start bit, eight bits low first, stop bit, then the strobe
	task automatic send_byte(input logic [7:0] b);
		for (int i = 0; i < 10; i++) begin
			@(negedge clock_i);
			rx_pin_o = (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
			repeat (BIT - 1) @(negedge clock_i);
		end
		rx_byte_o = b;
		rx_valid_o = 1'b1;
		repeat (4) @(negedge clock_i);
		rx_valid_o = 1'b0;
		repeat (2) @(negedge clock_i);
		rx_byte_o = ~b; // No stale byte once released
	endtask
	// Collect accepted bytes
	always @(posedge clock_i) begin
		if (tx_valid_i && tx_ready_o)
			got.push_back(tx_byte_i);
	end
	// Slow mode stalls every other cycle
	always @(negedge clock_i)
		tx_ready_o <= slow ? ~tx_ready_o : 1'b1;
endmodule

// ===== dv/tb_top.sv
// Top testbench for the boot framing engine.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/100ps
module tb_top;
	import frame_pkg::*;
	logic        clock_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic        rx_pin, rx_valid, tx_ready, tx_valid, out_ready, cmd_valid, cmd_data;
	logic        data_valid, data_end, out_abort, linked, last_data;
	logic        rsp_valid = 1'b0, rsp_read = 1'b0, rsp_data = 1'b0;
	logic [31:0] rsp_status = 32'h0;
	logic [7:0]  rx_byte, tx_byte, cmd_tag, data_byte, last_tag;
	logic [8:0]  bit_period;
	logic [7:0]  dq[$], ex[$], none[$];
	int          fails = 0, check_count = 0, cmds = 0, ends = 0, outs = 0;

	always #50 clock_i = ~clock_i;

	boot_serial_frame_protocol DUT (
		.clock_i(clock_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1), .rx_pin_i(rx_pin),
		.rx_valid_i(rx_valid), .rx_byte_i(rx_byte), .tx_ready_i(tx_ready),
		.rsp_valid_i(rsp_valid), .rsp_status_i(rsp_status), .rsp_read_i(rsp_read),
		.rsp_data_i(rsp_data), .out_valid_i(1'b0), .out_byte_i(8'h00), .out_last_i(1'b0),
		.out_done_i(1'b0), .tx_valid_o(tx_valid), .tx_byte_o(tx_byte),
		.out_ready_o(out_ready), .cmd_valid_o(cmd_valid), .cmd_tag_o(cmd_tag),
		.cmd_data_o(cmd_data), .data_valid_o(data_valid), .data_byte_o(data_byte),
		.data_end_o(data_end), .out_abort_o(out_abort), .bit_period_o(bit_period),
		.linked_o(linked));
	host_model u_host (.clock_i(clock_i), .tx_valid_i(tx_valid), .tx_byte_i(tx_byte),
		.tx_ready_o(tx_ready), .rx_pin_o(rx_pin), .rx_valid_o(rx_valid), .rx_byte_o(rx_byte));

	// Record what the user side delivers
	always @(posedge clock_i) begin
		if (cmd_valid) begin
			cmds <= cmds + 1;
			last_tag <= cmd_tag;
			last_data <= cmd_data;
		end
		if (data_valid)
			dq.push_back(data_byte);
		if (data_end)
			ends <= ends + 1;
		if (out_ready || out_abort)
			outs <= outs + 1;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask
	// Reference XMODEM CRC16, MSB first
	function automatic logic [15:0] crc_of(input logic [7:0] q[$]);
		logic [15:0] c;
		c = 16'h0000;
		foreach (q[j]) begin
			c = c ^ {q[j], 8'h00};
			for (int i = 0; i < 8; i++)
				c = c[15] ? ({c[14:0], 1'b0} ^ 16'h1021) : {c[14:0], 1'b0};
		end
		return c;
	endfunction
	task automatic send_frame(input logic [7:0] ty, input logic [7:0] pl[$], input bit bad);
		logic [7:0]  f[$];
		logic [15:0] c;
		f = {START_BYTE, ty, 8'(pl.size()), 8'(pl.size() >> 8)};
		c = crc_of({f, pl}) ^ {15'h0, bad};
		f = {f, c[7:0], c[15:8], pl};
		foreach (f[i]) u_host.send_byte(f[i]);
	endtask
	task automatic send_sync(input logic [7:0] ty);
		u_host.send_byte(START_BYTE);
		u_host.send_byte(ty);
	endtask
	// Wait for the expected byte count, then compare in order
	task automatic expect_tx(input string what);
		for (int n = 0; n < 4000 && u_host.got.size() < ex.size(); n++)
			@(posedge clock_i);
		check(u_host.got.size(), ex.size(), what);
		foreach (ex[i]) if (i < u_host.got.size()) check(u_host.got[i], ex[i], what);
		u_host.got.delete();
		ex.delete();
	endtask
	task automatic expect_sync(input logic [7:0] ty);
		ex = '{START_BYTE, ty};
		expect_tx("sync frame");
	endtask
	task automatic expect_reply(input logic [7:0] rt, fl, input logic [31:0] st,
		input logic [7:0] ct);
		logic [15:0] c;
		ex = {rt, fl, 8'h00, 8'h02, st[7:0], st[15:8], st[23:16], st[31:24], ct, 8'h00,
			8'h00, 8'h00};
		c = crc_of({START_BYTE, FRAME_TYPE_CMD, 8'h0C, 8'h00, ex});
		ex = {START_BYTE, FRAME_TYPE_CMD, 8'h0C, 8'h00, c[7:0], c[15:8], ex};
		expect_tx("reply frame");
	endtask
	task automatic wait_cmd(input int n);
		for (int i = 0; i < 300 && cmds < n; i++)
			@(posedge clock_i);
		check(cmds, n, "command count");
	endtask
	task automatic answer(input logic [31:0] st, input logic rd, dat);
		@(negedge clock_i);
		rsp_status = st;
		rsp_read = rd;
		rsp_data = dat;
		rsp_valid = 1'b1;
		@(negedge clock_i);
		rsp_valid = 1'b0;
	endtask

	task automatic t_refuse();
		send_frame(FRAME_TYPE_CMD, '{8'h07, 8'h00, 8'h00, 8'h00}, 0);
		repeat (200) @(posedge clock_i);
		check(u_host.got.size(), 0, "silent before probe");
		check(cmds, 0, "no command before probe");
		$display("test refuse done");
	endtask
	task automatic t_probe();
		logic [15:0] c;
		send_sync(FRAME_TYPE_PROBE);
		ex = {START_BYTE, FRAME_TYPE_PROBE_REPLY, PROTO_BUGFIX, PROTO_MINOR, PROTO_MAJOR,
			8'h50, 8'h00, 8'h00};
		c = crc_of(ex);
		ex = {ex, c[7:0], c[15:8]};
		expect_tx("probe reply");
		repeat (4) @(posedge clock_i);
		check(linked, 1'b1, "link open");
		check(bit_period, u_host.BIT, "bit period measured");
		$display("test probe done");
	endtask
	task automatic t_cmd();
		u_host.slow = 1'b1;
		send_frame(FRAME_TYPE_CMD, '{8'h07, 8'h00, 8'h00, 8'h00}, 0);
		expect_sync(FRAME_TYPE_ACCEPT);
		wait_cmd(1);
		check(last_tag, 8'h07, "command tag");
		check(last_data, 1'b0, "no data flag");
		answer(STATUS_OK_CODE, 0, 0);
		expect_reply(GENERAL_REPLY_TAG, 8'h00, STATUS_OK_CODE, 8'h07);
		send_sync(FRAME_TYPE_ACCEPT);
		u_host.slow = 1'b0;
		send_frame(FRAME_TYPE_CMD, '{8'h07, 8'h00, 8'h00, 8'h00}, 1);
		expect_sync(FRAME_TYPE_RETRY);
		check(cmds, 1, "corrupt frame dropped");
		$display("test command done");
	endtask
	task automatic t_in();
		send_frame(FRAME_TYPE_CMD, '{8'h04, 8'h01, 8'h00, 8'h00}, 0);
		expect_sync(FRAME_TYPE_ACCEPT);
		wait_cmd(2);
		check(last_data, 1'b1, "data flag");
		answer(STATUS_OK_CODE, 0, 0);
		expect_reply(GENERAL_REPLY_TAG, 8'h00, STATUS_OK_CODE, 8'h04);
		send_sync(FRAME_TYPE_ACCEPT);
		send_frame(FRAME_TYPE_PAYLOAD, '{8'h3C, 8'hC3}, 0);
		expect_sync(FRAME_TYPE_ACCEPT);
		check(dq.size(), 2, "payload count");
		check(dq[0], 8'h3C, "payload byte 0");
		check(dq[1], 8'hC3, "payload byte 1");
		send_frame(FRAME_TYPE_PAYLOAD, none, 0);
		expect_sync(FRAME_TYPE_ACCEPT);
		check(ends, 1, "empty packet ends phase");
		answer(32'h0000_0042, 0, 0);
		expect_reply(GENERAL_REPLY_TAG, 8'h00, 32'h0000_0042, 8'h04);
		send_sync(FRAME_TYPE_ACCEPT);
		$display("test inbound done");
	endtask
	task automatic t_read();
		send_frame(FRAME_TYPE_CMD, '{8'h03, 8'h00, 8'h00, 8'h00}, 0);
		expect_sync(FRAME_TYPE_ACCEPT);
		wait_cmd(3);
		answer(STATUS_OK_CODE, 1, 0);
		expect_reply(MEMORY_READ_REPLY_TAG, 8'h00, STATUS_OK_CODE, 8'h03);
		send_sync(FRAME_TYPE_ACCEPT);
		send_sync(FRAME_TYPE_CANCEL);
		repeat (100) @(posedge clock_i);
		check(outs, 0, "no outbound phase");
		check(u_host.got.size(), 0, "no data frame");
		$display("test read done");
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (2) @(negedge clock_i);
		sys_rst_i = 1'b0;
		t_refuse();
		t_probe();
		t_cmd();
		t_in();
		t_read();
		results();
	end
	// Watchdog well beyond the expected run of some seven thousand cycles
	initial begin
		repeat (60000) @(posedge clock_i);
		fails++;
		results();
	end
endmodule

bind boot_serial_frame_protocol frame_props u_props (.clock_i, .sys_rst_i, .tx_ready_i,
	.tx_valid_o, .tx_byte_o, .cmd_valid_o, .data_valid_o, .data_end_o, .bit_period_o,
	.linked_o);
